// File: pkg/rcc_params.svh
// Constants for the receive channel command controller
`ifndef RCC_PARAMS_SVH
`define RCC_PARAMS_SVH
// --------------------------------------------------------------
// Sizes
// --------------------------------------------------------------
`define RCC_NCH 8
`define RCC_TXB_DWORDS 7'h40
// --------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------
`define RCC_OFF_SPEC 8'h00
`define RCC_OFF_FIRST_RX_DESCRIPTOR_ADDR 8'h04
`define RCC_OFF_FIRST_TX_DESCRIPTOR_ADDR 8'h08
`define RCC_OFF_CFG 8'h0C
`define RCC_OFF_ACTION 8'h10
`define RCC_OFF_STATUS 8'h14
// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define RCC_MASK_HI 31
`define RCC_MASK_LO 24
`define RCC_NEW_BUFFER_SIZE_FLAG 23
`define RCC_CMD_HI 22
`define RCC_CMD_LO 16
`define RCC_TX_BUFFER_DWORDS_HI 5
`define RCC_MODE_HI 10
`define RCC_MODE_LO 8
`define RCC_INV 11
`define RCC_ACT_GO 8
`define RCC_ST_BUSY 0
`define RCC_ST_ARF 1
`define RCC_ST_FREE_LO 8
// Mask bits within the 8-bit mask field
`define RCC_M_FE2 7
`define RCC_M_SFE 6
`define RCC_M_IFC 5
`define RCC_M_CH 4
`define RCC_M_RE 2
`define RCC_M_FIR 1
// Interrupt information word bits
`define RCC_I_FRC 32'h0080_0000
`define RCC_I_CH 32'h00FF_E000
`define RCC_I_FI 32'h0000_0800
`define RCC_I_IFC 32'h0000_0400
`define RCC_I_SF 32'h0000_0200
`define RCC_I_ERR 32'h0000_0100
`define RCC_I_FO 32'h0000_0080
`define RCC_I_EVT 32'h00FF_FFE0
// --------------------------------------------------------------
// Modes, receive command patterns, DMA operations
// --------------------------------------------------------------
`define RCC_MD_BITO 3'h0
`define RCC_MD_RATE 3'h1
`define RCC_MD_TRA 3'h2
`define RCC_MD_TRB 3'h3
`define RCC_MD_TRR 3'h4
`define RCC_RX_CLEAR 3'h0
`define RCC_RX_FAST 3'h1
`define RCC_RX_OFF 3'h2
`define RCC_RX_ABORT 3'h3
`define RCC_RX_JUMP 3'h4
`define RCC_RX_INIT 3'h5
`define RCC_DMA_CLOSE_ABORT 2'h0
`define RCC_DMA_JUMP 2'h1
`define RCC_DMA_START 2'h2
`define RCC_DMA_ABANDON 2'h3
// --------------------------------------------------------------
// Receive abort bit limits
// --------------------------------------------------------------
`define RCC_LIM_BITO_FRAME 8'h07
`define RCC_LIM_BITO_FILL 8'h0F
`define RCC_LIM_RATE 8'hF0
`define RCC_LIM_TRB 8'h0F
`define RCC_LIM_TRR 8'h1F
`endif

// File: pkg/rcc_pkg.sv
// Types of the receive channel command controller
`include "rcc_params.svh"
package rcc_pkg;
  typedef enum logic [2:0] {
    RCC_IDLE = 3'b001,
    RCC_FETCH = 3'b010,
    RCC_EXEC = 3'b100
  } rcc_state_e;

  typedef struct packed {
    logic loop;
    logic synced;
    logic fill;
    logic infr;
    logic start;
    logic [2:0] chan;
    logic stb;
    logic bit_in;
  } rcc_pins_s;

  typedef struct packed {
    logic init;
    logic off;
    logic abort;
    logic wait_sof;
    logic data_invert_setting;
    logic [2:0] mode;
    logic [7:0] mask;
    logic [7:0] cnt;
    logic [5:0] alloc;
  } rcc_chan_s;

  typedef struct packed {
    rcc_chan_s [`RCC_NCH-1:0] ent;
    rcc_chan_s rd;
  } rcc_mem_s;

  typedef struct packed {
    rcc_state_e st;
    logic [2:0] ch;
    logic isact;
    logic [31:0] spec;
    logic [31:0] first_rx_descriptor_addr;
    logic [31:0] first_tx_descriptor_addr;
    logic [15:0] cfg;
    logic act_pend;
    logic [2:0] act_ch;
    logic arf;
    logic [6:0] free;
    rcc_pins_s s1;
    rcc_pins_s s2;
    logic stb_d;
    logic bit_pend;
    rcc_pins_s pb;
    logic a_wr;
    logic a_rd;
    logic [7:0] a_addr;
    logic hready_o;
    logic [31:0] hrdata_o;
    logic hresp_o;
    logic rx_out_bit;
    logic rx_out_valid;
    logic [2:0] rx_out_chan;
    logic deform_reset;
    logic [2:0] deform_chan;
    logic dma_valid;
    logic [1:0] dma_op;
    logic [2:0] dma_chan;
    logic [31:0] dma_addr;
    logic int_valid;
    logic [31:0] int_word;
    logic arf_pulse;
    logic tx_cmd_valid;
    logic [3:0] tx_cmd;
    logic [2:0] tx_chan;
  } rcc_regs_s;
endpackage : rcc_pkg

// File: logic/rcc_chan_mem.sv
// Per-channel receive condition table with registered read
`timescale 1ns/1ps
`include "rcc_params.svh"
module rcc_chan_mem
  import rcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] raddr,
  output rcc_chan_s rdata,
  input wire logic we,
  input wire logic [2:0] waddr,
  input rcc_chan_s wdata
);
  rcc_mem_s q;
  rcc_mem_s next_q;
  rcc_chan_s [`RCC_NCH-1:0] next_ent;

  // --------------------------------------------------------------
  // Entries
  // --------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `RCC_NCH; gi++)
    begin : g_ent
      assign next_ent[gi] = (we && waddr == 3'(gi)) ? wdata : q.ent[gi];
    end
  endgenerate

  always_comb
  begin
    next_q = q;
    next_q.ent = next_ent;
    next_q.rd = q.ent[raddr];
  end

  // Cleared table means every channel starts never initialised
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign rdata = q.rd;
endmodule : rcc_chan_mem

// File: logic/rcc_ctrl.sv
// Channel specification fetch and receive command control
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rcc_params.svh"
// Operation
// - Spec takes effect only on action request
// - Mask bits gate matching interrupt word bits
// - Partial mask keeps interrupt; full suppresses
// - New size: release old, then allocate
// - No room: failure interrupt, nothing allocated
// - Command bits split into three groups
// - Clear lifts off/abort on initialised channel
// - Fast abort closes descriptor, branches
// - Fast abort interrupt frame+error or error
// - Off resets deformatter, ignored under loop
// - After off, wait for frame start
// - Abort substitutes ones or zeros, ignoring inversion
// - Bit-oriented abort ends within 7/15 bits
// - Rate abort loses sync within 240 bits
// - Transparent abort ends within 15/31 bits
// - Jump completes descriptor then branches
// - Init starts chain or abandons descriptor
module rcc_ctrl
  import rcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rx_bit,
  input wire logic rx_bit_stb,
  input wire logic [2:0] rx_bit_chan,
  input wire logic rx_frame_start,
  input wire logic rx_in_frame,
  input wire logic rx_flag_fill,
  input wire logic rx_synced,
  input wire logic rx_loop,
  output logic rx_out_bit,
  output logic rx_out_valid,
  output logic [2:0] rx_out_chan,
  output logic deform_reset,
  output logic [2:0] deform_chan,
  output logic dma_valid,
  output logic [1:0] dma_op,
  output logic [2:0] dma_chan,
  output logic [31:0] dma_addr,
  output logic int_valid,
  output logic [31:0] int_word,
  output logic arf_pulse,
  output logic tx_cmd_valid,
  output logic [3:0] tx_cmd,
  output logic [2:0] tx_chan
);
  rcc_regs_s q;
  rcc_regs_s next_q;
  rcc_chan_s w;
  rcc_chan_s nw;
  logic mem_we;
  logic [2:0] rxg;
  logic [7:0] new_mask;
  logic [6:0] freed;
  logic [6:0] tx_buffer_dwords;
  logic [2:0] cfg_md;

  rcc_chan_mem u_mem (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .raddr(q.ch),
    .rdata(w),
    .we(mem_we),
    .waddr(q.ch),
    .wdata(nw)
  );

  // Decoded from the staged spec; only used in an action
  assign rxg = {q.spec[`RCC_CMD_HI], q.spec[`RCC_CMD_LO+1],
                q.spec[`RCC_CMD_LO]};
  assign new_mask = q.spec[`RCC_MASK_HI:`RCC_MASK_LO];
  assign freed = 7'(q.free + {1'b0, w.alloc});
  assign tx_buffer_dwords = {1'b0, q.cfg[`RCC_TX_BUFFER_DWORDS_HI:0]};
  assign cfg_md = q.cfg[`RCC_MODE_HI:`RCC_MODE_LO];

  // --------------------------------------------------------------
  // Interrupt masking
  // --------------------------------------------------------------
  function automatic logic [31:0] apply_mask(input logic [31:0] evt,
                                              input logic [7:0] m);
    logic [31:0] kill;
    kill = '0;
    if (m[`RCC_M_FIR])
      kill = kill | `RCC_I_FI;
    if (m[`RCC_M_IFC])
      kill = kill | `RCC_I_IFC;
    if (m[`RCC_M_SFE])
      kill = kill | `RCC_I_SF;
    if (m[`RCC_M_RE])
      kill = kill | `RCC_I_ERR | `RCC_I_FO;
    if (m[`RCC_M_CH])
      kill = kill | `RCC_I_CH;
    return evt & ~kill;
  endfunction : apply_mask

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    logic edge_stb;
    logic frame_md;
    logic [31:0] evt;
    logic [7:0] lim;
    logic [7:0] cnt1;
    edge_stb = 1'b0;
    frame_md = 1'b0;
    evt = '0;
    lim = '0;
    cnt1 = '0;
    next_q = q;
    nw = w;
    mem_we = 1'b0;
    next_q.rx_out_valid = 1'b0;
    next_q.deform_reset = 1'b0;
    next_q.dma_valid = 1'b0;
    next_q.int_valid = 1'b0;
    next_q.arf_pulse = 1'b0;
    next_q.tx_cmd_valid = 1'b0;
    // Pins cross in two stages before any use
    next_q.s1 = {rx_loop, rx_synced, rx_flag_fill, rx_in_frame,
                 rx_frame_start, rx_bit_chan, rx_bit_stb, rx_bit};
    next_q.s2 = q.s1;
    next_q.stb_d = q.s2.stb;
    edge_stb = q.s2.stb && !q.stb_d;
    // Bus: writes land in the data phase, reads take one wait state
    next_q.a_wr = 1'b0;
    if (q.a_wr)
    begin
      unique case (q.a_addr)
        `RCC_OFF_SPEC: next_q.spec = hwdata;
        `RCC_OFF_FIRST_RX_DESCRIPTOR_ADDR: next_q.first_rx_descriptor_addr = hwdata;
        `RCC_OFF_FIRST_TX_DESCRIPTOR_ADDR: next_q.first_tx_descriptor_addr = hwdata;
        `RCC_OFF_CFG: next_q.cfg = hwdata[15:0];
        `RCC_OFF_ACTION:
          if (hwdata[`RCC_ACT_GO] && !q.act_pend)
          begin
            next_q.act_pend = 1'b1;
            next_q.act_ch = hwdata[2:0];
          end
        `RCC_OFF_STATUS:
          if (hwdata[`RCC_ST_ARF])
            next_q.arf = 1'b0;
        default: ;
      endcase
    end
    if (q.a_rd)
    begin
      next_q.a_rd = 1'b0;
      next_q.hready_o = 1'b1;
      unique case (q.a_addr)
        `RCC_OFF_SPEC: next_q.hrdata_o = q.spec;
        `RCC_OFF_FIRST_RX_DESCRIPTOR_ADDR: next_q.hrdata_o = q.first_rx_descriptor_addr;
        `RCC_OFF_FIRST_TX_DESCRIPTOR_ADDR: next_q.hrdata_o = q.first_tx_descriptor_addr;
        `RCC_OFF_CFG: next_q.hrdata_o = {16'h0000, q.cfg};
        `RCC_OFF_STATUS: next_q.hrdata_o = {17'h00000, q.free,
          6'h00, q.arf, (q.act_pend || q.st != RCC_IDLE)};
        default: next_q.hrdata_o = 32'h0000_0000;
      endcase
    end
    if (hsel && htrans[1] && hready)
    begin
      next_q.a_addr = haddr[7:0];
      next_q.a_wr = hwrite;
      next_q.a_rd = !hwrite;
      next_q.hready_o = hwrite;
    end
    // Channel sequencer
    unique case (q.st)
      RCC_IDLE:
        if (q.act_pend)
        begin
          next_q.act_pend = 1'b0;
          next_q.ch = q.act_ch;
          next_q.isact = 1'b1;
          next_q.st = RCC_FETCH;
        end
        else if (q.bit_pend)
        begin
          next_q.bit_pend = 1'b0;
          next_q.ch = q.pb.chan;
          next_q.isact = 1'b0;
          next_q.st = RCC_FETCH;
        end
      RCC_FETCH:
        next_q.st = RCC_EXEC;
      RCC_EXEC:
      begin
        next_q.st = RCC_IDLE;
        mem_we = 1'b1;
        if (q.isact)
        begin
          nw.mask = new_mask;
          nw.mode = q.cfg[`RCC_MODE_HI:`RCC_MODE_LO];
          nw.data_invert_setting = q.cfg[`RCC_INV];
          frame_md = nw.mode == `RCC_MD_BITO || nw.mode == `RCC_MD_TRB
                     || nw.mode == `RCC_MD_TRR;
          // Transmit groups handed on undecoded beyond splitting
          next_q.tx_cmd_valid = 1'b1;
          next_q.tx_cmd = q.spec[`RCC_CMD_HI-1:`RCC_CMD_LO+2];
          next_q.tx_chan = q.ch;
          if (q.spec[`RCC_NEW_BUFFER_SIZE_FLAG])
          begin
            // Old area is returned before the new one is sized
            if (tx_buffer_dwords <= freed)
            begin
              nw.alloc = q.cfg[`RCC_TX_BUFFER_DWORDS_HI:0];
              next_q.free = 7'(freed - tx_buffer_dwords);
            end
            else
            begin
              nw.alloc = '0;
              next_q.free = freed;
              next_q.arf = 1'b1;
              next_q.arf_pulse = 1'b1;
            end
          end
          next_q.dma_chan = q.ch;
          next_q.dma_addr = q.first_rx_descriptor_addr;
          next_q.deform_chan = q.ch;
          unique case (rxg)
            `RCC_RX_CLEAR:
              if (w.init)
              begin
                nw.off = 1'b0;
                nw.abort = 1'b0;
                nw.wait_sof = w.wait_sof || w.off;
              end
            `RCC_RX_FAST:
              if (w.init)
              begin
                nw.off = 1'b0;
                nw.abort = 1'b0;
                nw.wait_sof = w.wait_sof || w.off;
                next_q.dma_valid = 1'b1;
                next_q.dma_op = `RCC_DMA_CLOSE_ABORT;
                evt = frame_md ? (`RCC_I_FI | `RCC_I_ERR) : `RCC_I_ERR;
                evt = apply_mask(evt, new_mask);
              end
            `RCC_RX_OFF:
              if (!q.s2.loop)
              begin
                nw.off = 1'b1;
                nw.abort = 1'b0;
                next_q.deform_reset = 1'b1;
              end
            `RCC_RX_ABORT:
            begin
              nw.off = 1'b0;
              nw.abort = 1'b1;
              nw.cnt = '0;
            end
            `RCC_RX_JUMP:
            begin
              nw.off = 1'b0;
              nw.abort = 1'b0;
              nw.wait_sof = w.wait_sof || w.off;
              next_q.dma_valid = 1'b1;
              next_q.dma_op = `RCC_DMA_JUMP;
            end
            `RCC_RX_INIT:
            begin
              nw.off = 1'b0;
              nw.abort = 1'b0;
              nw.init = 1'b1;
              nw.wait_sof = !w.init || w.wait_sof || w.off;
              next_q.dma_valid = 1'b1;
              next_q.dma_op = w.init ? `RCC_DMA_ABANDON : `RCC_DMA_START;
            end
            default: ;
          endcase
        end
        else if (w.abort)
        begin
          // Substitute level ignores inversion on purpose
          next_q.rx_out_valid = 1'b1;
          next_q.rx_out_bit = w.mode == `RCC_MD_BITO;
          cnt1 = (w.cnt == 8'hFF) ? w.cnt : 8'(w.cnt + 8'h01);
          nw.cnt = cnt1;
          unique case (w.mode)
            `RCC_MD_BITO:
            begin
              lim = q.pb.infr ? `RCC_LIM_BITO_FRAME :
                    (q.pb.fill ? `RCC_LIM_BITO_FILL : 8'h00);
              evt = q.pb.infr ? (`RCC_I_FI | `RCC_I_ERR) : `RCC_I_IFC;
            end
            `RCC_MD_RATE:
            begin
              lim = q.pb.synced ? `RCC_LIM_RATE : 8'h00;
              evt = `RCC_I_ERR | `RCC_I_FRC;
            end
            `RCC_MD_TRB:
            begin
              lim = q.pb.infr ? `RCC_LIM_TRB : 8'h00;
              evt = `RCC_I_FI;
            end
            `RCC_MD_TRR:
            begin
              lim = q.pb.infr ? `RCC_LIM_TRR : 8'h00;
              evt = `RCC_I_FI;
            end
            default: lim = 8'h00;
          endcase
          evt = (lim != 8'h00 && cnt1 == lim && w.cnt != lim) ?
                apply_mask(evt, w.mask) : 32'h0000_0000;
        end
        else if (w.init && !w.off)
        begin
          if (!w.wait_sof || q.pb.start)
          begin
            nw.wait_sof = 1'b0;
            next_q.rx_out_valid = 1'b1;
            next_q.rx_out_bit = q.pb.bit_in ^ w.data_invert_setting;
          end
        end
        next_q.rx_out_chan = q.ch;
        // A word with every event bit masked is never sent
        if ((evt & `RCC_I_EVT) != 32'h0000_0000)
        begin
          next_q.int_valid = 1'b1;
          next_q.int_word = evt | {27'h0000000, 2'b00, q.ch};
        end
      end
      default: next_q.st = RCC_IDLE;
    endcase
    // Capture last so a new strobe is never lost to the clear
    if (edge_stb)
    begin
      next_q.bit_pend = 1'b1;
      next_q.pb = q.s2;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.st <= RCC_IDLE;
      q.hready_o <= 1'b1;
      q.free <= `RCC_TXB_DWORDS;
    end
    else
      q <= next_q;
  end

  assign hreadyout = q.hready_o;
  assign hrdata = q.hrdata_o;
  assign hresp = q.hresp_o;
  assign rx_out_bit = q.rx_out_bit;
  assign rx_out_valid = q.rx_out_valid;
  assign rx_out_chan = q.rx_out_chan;
  assign deform_reset = q.deform_reset;
  assign deform_chan = q.deform_chan;
  assign dma_valid = q.dma_valid;
  assign dma_op = q.dma_op;
  assign dma_chan = q.dma_chan;
  assign dma_addr = q.dma_addr;
  assign int_valid = q.int_valid;
  assign int_word = q.int_word;
  assign arf_pulse = q.arf_pulse;
  assign tx_cmd_valid = q.tx_cmd_valid;
  assign tx_cmd = q.tx_cmd;
  assign tx_chan = q.tx_chan;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_act_after_req: assert property (
    (q.st == RCC_EXEC && q.isact) |->
      $past(q.st == RCC_FETCH) && $past(q.st == RCC_IDLE, 2))
    else $error("action executed without request");
  a_int_not_empty: assert property (
    int_valid |-> (int_word & `RCC_I_EVT) != 32'h0000_0000)
    else $error("interrupt with all bits masked");
  a_fast_abort_dma: assert property (
    (q.st == RCC_EXEC && q.isact && rxg == `RCC_RX_FAST && w.init)
      |=> dma_valid && dma_op == `RCC_DMA_CLOSE_ABORT && int_valid
          == (apply_mask(`RCC_I_ERR, $past(new_mask)) != '0 ||
              (apply_mask(`RCC_I_FI, $past(new_mask)) != '0 &&
               $past(cfg_md == `RCC_MD_BITO || cfg_md == `RCC_MD_TRB
                     || cfg_md == `RCC_MD_TRR))))
    else $error("fast abort not closed");
  a_off_deform: assert property (
    (q.st == RCC_EXEC && q.isact && rxg == `RCC_RX_OFF)
      |=> deform_reset == !$past(q.s2.loop))
    else $error("receive off deformatter reset wrong");
  a_jump_dma: assert property (
    (q.st == RCC_EXEC && q.isact && rxg == `RCC_RX_JUMP)
      |=> dma_valid && dma_op == `RCC_DMA_JUMP && dma_addr == q.first_rx_descriptor_addr)
    else $error("jump not issued");
  a_init_dma: assert property (
    (q.st == RCC_EXEC && q.isact && rxg == `RCC_RX_INIT)
      |=> dma_valid && dma_op == ($past(w.init) ? `RCC_DMA_ABANDON
                                                 : `RCC_DMA_START))
    else $error("init chose wrong descriptor action");
  a_abort_level: assert property (
    (q.st == RCC_EXEC && !q.isact && w.abort) |=>
      rx_out_valid && rx_out_bit == ($past(w.mode) == `RCC_MD_BITO))
    else $error("abort substitution wrong");
  a_reserved_quiet: assert property (
    (q.st == RCC_EXEC && q.isact && rxg[2:1] == 2'b11)
      |=> !dma_valid && !deform_reset ##0 $stable(q.free) || arf_pulse
          || $past(q.spec[`RCC_NEW_BUFFER_SIZE_FLAG]))
    else $error("reserved pattern had effect");
  a_pool_fail: assert property (
    (q.st == RCC_EXEC && q.isact && q.spec[`RCC_NEW_BUFFER_SIZE_FLAG] && tx_buffer_dwords > freed)
      |=> arf_pulse && q.arf ##1 !arf_pulse)
    else $error("allocation failure not flagged");
  a_pool_bound: assert property (
    q.free <= `RCC_TXB_DWORDS)
    else $error("transmit pool overfilled");

  c_fast_abort: cover property (dma_valid &&
    dma_op == `RCC_DMA_CLOSE_ABORT && int_valid);
  c_abort_int: cover property (rx_out_valid && int_valid);
  c_alloc_fail: cover property (arf_pulse);
  c_wait_start: cover property (q.st == RCC_EXEC && !q.isact &&
    w.wait_sof && q.pb.start);
endmodule : rcc_ctrl

// File: tb/rcc_host.sv
// Host model: AHB-Lite master that hands channel specs to the block
`timescale 1ns/1ps
`include "rcc_params.svh"
module rcc_host (
  input wire logic clk_sys,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ----------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------
  initial
  begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Entered just after a rising edge; waits as long as the slave stalls
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  // Serial-core channels only, so the local-port size is never due
  task automatic issue(input logic [2:0] ch, input logic [31:0] spec,
                       input logic [15:0] cfg);
    logic [31:0] r;
    logic [15:0] c;
    c = cfg;
    if (spec[`RCC_NEW_BUFFER_SIZE_FLAG] == 1'b0)
      c[5:0] = 6'h00;
    // Settings go out with every spec; the bench keeps only the descriptor address fixed
    xfer(1'b1, `RCC_OFF_CFG, {16'h0, c}, r);
    xfer(1'b1, `RCC_OFF_FIRST_RX_DESCRIPTOR_ADDR, 32'h0000_1000, r);
    xfer(1'b1, `RCC_OFF_SPEC, spec, r);
    xfer(1'b1, `RCC_OFF_ACTION, {23'h0, 1'b1, 5'h0, ch}, r);
  endtask : issue
endmodule : rcc_host

// File: tb/tb.sv
// Testbench for the receive channel command controller
`timescale 1ns/1ps
`include "rcc_params.svh"
module tb;
  logic clk_sys, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, dma_addr, int_word;
  logic [1:0] htrans, dma_op;
  logic [2:0] hsize, rx_bit_chan, rx_out_chan, deform_chan, dma_chan;
  logic [2:0] tx_chan;
  logic rx_bit, rx_bit_stb, rx_frame_start, rx_in_frame, rx_flag_fill;
  logic rx_synced, rx_loop, rx_out_bit, rx_out_valid, deform_reset;
  logic dma_valid, int_valid, arf_pulse, tx_cmd_valid;
  logic [3:0] tx_cmd, last_out, last_tx;
  logic [31:0] last_int;
  logic [36:0] last_dma;
  logic [2:0] last_dr;
  int miscompares = 0, checks_done = 0;
  int n_int = 0, n_dma = 0, n_out = 0, n_dr = 0, n_arf = 0;
  assign hready = hreadyout;
  rcc_ctrl u_rcc_ctrl (.*);
  rcc_host host (.*);
  // ----------------------------------------------------------
  // Clock, monitors, helpers
  // ----------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Pulses last one cycle, so they are caught at every edge
  always @(posedge clk_sys)
  begin
    if (int_valid === 1'b1) {n_int, last_int} <= {n_int + 1, int_word};
    if (dma_valid === 1'b1)
      {n_dma, last_dma} <= {n_dma + 1, dma_op, dma_chan, dma_addr};
    if (rx_out_valid === 1'b1)
      {n_out, last_out} <= {n_out + 1, rx_out_chan, rx_out_bit};
    if (deform_reset === 1'b1) {n_dr, last_dr} <= {n_dr + 1, deform_chan};
    if (arf_pulse === 1'b1) n_arf <= n_arf + 1;
    if (tx_cmd_valid === 1'b1) last_tx <= tx_cmd;
  end

  task chk(input string nm, input logic [36:0] seen, input logic [36:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] sp(input logic [7:0] m, input logic n,
                                     input logic [2:0] rx, input logic [3:0] tx);
    sp = {m, n, rx[2], tx, rx[1:0], 16'h0000};
  endfunction : sp

  // Action runs three cycles after the go write; ten leaves margin
  task act(input logic [2:0] ch, input logic [31:0] s, input logic [15:0] c);
    host.issue(ch, s, c);
    repeat (10) @(posedge clk_sys);
  endtask : act

  // One zero bit on rx_bit_chan; pins stay put well past the strobe
  task send(input logic fs);
    rx_bit <= 1'b0;
    rx_frame_start <= fs;
    rx_bit_stb <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rx_bit_stb <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : send

  task rd(input logic [7:0] a, output logic [31:0] r);
    host.xfer(1'b0, a, 32'h0, r);
  endtask : rd
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task t_dma;
    int b;
    logic [31:0] r;
    rd(`RCC_OFF_STATUS, r);
    chk("free_pool", r, 32'h0000_4000);
    chk("hresp", hresp, 1'b0);
    rd(8'h18, r);
    chk("unmapped", r, 32'h0);
    act(3'h2, sp(8'h00, 1'b0, `RCC_RX_FAST, 4'h0), 16'h0);
    chk("uninit", n_dma, 0);
    act(3'h1, sp(8'h00, 1'b0, `RCC_RX_INIT, 4'h0), 16'h0);
    chk("init", last_dma, {`RCC_DMA_START, 3'h1, 32'h1000});
    act(3'h1, sp(8'h00, 1'b0, `RCC_RX_INIT, 4'h0), 16'h0);
    chk("reinit", last_dma, {`RCC_DMA_ABANDON, 3'h1, 32'h1000});
    chk("reinit_int", n_int, 0);
    act(3'h1, sp(8'h00, 1'b0, `RCC_RX_JUMP, 4'h1), 16'h0);
    chk("jump", last_dma, {`RCC_DMA_JUMP, 3'h1, 32'h1000});
    chk("tx_group", last_tx, 4'h1);
    chk("tx_chan", tx_chan, 3'h1);
    act(3'h1, sp(8'h00, 1'b0, `RCC_RX_FAST, 4'h0), 16'h0);
    chk("fast", last_dma, {`RCC_DMA_CLOSE_ABORT, 3'h1, 32'h1000});
    chk("fast_int", last_int, `RCC_I_FI | `RCC_I_ERR | 32'h1);
    act(3'h1, sp(8'h04, 1'b0, `RCC_RX_FAST, 4'h0), 16'h0);
    chk("part_mask", last_int, `RCC_I_FI | 32'h1);
    b = n_int;
    act(3'h1, sp(8'h06, 1'b0, `RCC_RX_FAST, 4'h0), 16'h0);
    chk("full_mask", n_int, b);
    b = n_dma;
    act(3'h1, sp(8'h00, 1'b0, 3'h6, 4'h0), 16'h0);
    chk("reserved", n_dma, b);
  endtask : t_dma

  task t_abort_off;
    int b;
    act(3'h1, sp(8'h00, 1'b0, `RCC_RX_ABORT, 4'h0), 16'h0);
    b = n_int;
    for (int i = 0; i < 6; i++) send(i == 0);
    chk("abort_bit", last_out, 4'h3);
    chk("abort_early", n_int, b);
    send(1'b0);
    chk("abort_int", last_int, `RCC_I_FI | `RCC_I_ERR | 32'h1);
    chk("abort_cnt", n_int, b + 1);
    repeat (9) send(1'b0);
    chk("abort_once", n_int, b + 1);
    rx_loop <= 1'b1;
    act(3'h1, sp(8'h00, 1'b0, `RCC_RX_OFF, 4'h0), 16'h0);
    chk("off_loop", n_dr, 0);
    rx_loop <= 1'b0;
    act(3'h1, sp(8'h00, 1'b0, `RCC_RX_OFF, 4'h0), 16'h0);
    chk("off_reset", {n_dr[7:0], last_dr}, {8'h1, 3'h1});
    b = n_out;
    send(1'b0);
    chk("off_rx", n_out, b);
    act(3'h1, sp(8'h00, 1'b0, `RCC_RX_CLEAR, 4'h0), 16'h0);
    send(1'b0);
    chk("wait_sof", n_out, b);
    send(1'b1);
    chk("resume", {n_out[7:0], last_out}, {b[7:0] + 8'h1, 4'h2});
  endtask : t_abort_off

  task t_alloc;
    logic [31:0] r;
    act(3'h3, sp(8'h00, 1'b1, `RCC_RX_INIT, 4'h0), 16'h003F);
    rd(`RCC_OFF_STATUS, r);
    chk("alloc", r, 32'h0000_0100);
    act(3'h4, sp(8'h00, 1'b1, `RCC_RX_INIT, 4'h0), 16'h0002);
    rd(`RCC_OFF_STATUS, r);
    chk("no_room", {n_arf[3:0], r}, {4'h1, 32'h0000_0102});
    act(3'h3, sp(8'h00, 1'b1, `RCC_RX_INIT, 4'h0), 16'h0002);
    rd(`RCC_OFF_STATUS, r);
    chk("realloc", r, 32'h0000_3E02);
  endtask : t_alloc

  task t_modes;
    int b;
    rx_bit_chan <= 3'h2;
    act(3'h2, sp(8'h00, 1'b0, `RCC_RX_INIT, 4'h0), 16'h0A00);
    act(3'h2, sp(8'h00, 1'b0, `RCC_RX_FAST, 4'h0), 16'h0A00);
    chk("fast_tra", last_int, `RCC_I_ERR | 32'h2);
    act(3'h2, sp(8'h00, 1'b0, `RCC_RX_ABORT, 4'h0), 16'h0A00);
    b = n_int;
    repeat (8) send(1'b0);
    chk("tra_quiet", n_int, b);
    act(3'h2, sp(8'h00, 1'b0, `RCC_RX_OFF, 4'h0), 16'h0B00);
    act(3'h2, sp(8'h00, 1'b0, `RCC_RX_INIT, 4'h0), 16'h0B00);
    act(3'h2, sp(8'h00, 1'b0, `RCC_RX_ABORT, 4'h0), 16'h0B00);
    repeat (15) send(1'b0);
    chk("zero_sub", last_out, 4'h4);
    chk("trb_cnt", n_int, b + 1);
    chk("trb_int", last_int, `RCC_I_FI | 32'h2);
  endtask : t_modes
  // ----------------------------------------------------------
  // Run control
  // ----------------------------------------------------------
  task close_out;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // About a thousand cycles are needed; five thousand means a hang
  initial
  begin
    #250000;
    miscompares++;
    close_out;
  end

  initial
  begin
    reset_n = 1'b0;
    {rx_bit, rx_bit_stb, rx_frame_start, rx_flag_fill, rx_synced} = 5'h00;
    rx_in_frame = 1'b1;
    rx_loop = 1'b0;
    rx_bit_chan = 3'h1;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_dma;
    t_abort_off;
    t_modes;
    t_alloc;
    close_out;
  end
endmodule : tb
